/* src/capture_pkg.sv */
// shared constants and types for the pipeline test capture block
package capture_pkg;

    // -----------------------------------------------------------------
    // host port register indices
    // -----------------------------------------------------------------
    localparam int          SEL_W         = 4;
    localparam logic [3:0]  IDX_CMD2      = 4'h2;
    localparam logic [3:0]  IDX_PIX_MASK  = 4'h4;
    localparam logic [3:0]  IDX_PIX_CAP   = 4'h5;
    localparam logic [3:0]  IDX_CONV_CAP  = 4'h6;
    localparam logic [3:0]  IDX_STAT_CAP  = 4'h7;

    // -----------------------------------------------------------------
    // second command register fields and reset values
    // -----------------------------------------------------------------
    localparam int          CMD2_EDGE_BIT = 0;
    localparam int          CMD2_8BIT_BIT = 1;
    localparam int          CMD2_SIX_BIT  = 2;
    localparam logic [7:0]  CMD2_RESET    = 8'h01;
    localparam logic [7:0]  MASK_RESET    = 8'hff;

    // -----------------------------------------------------------------
    // pipeline geometry
    // -----------------------------------------------------------------
    localparam int          RED_TOP       = 7;
    localparam int          CONV_DELAY    = 4;
    localparam logic [2:0]  SEQ_THREE     = 3'h3;
    localparam logic [2:0]  SEQ_SIX       = 3'h6;
    localparam logic [2:0]  SEQ_ONE       = 3'h1;

    // -----------------------------------------------------------------
    // controller registers on the bus
    // -----------------------------------------------------------------
    localparam logic [7:0]  OFF_CTRL      = 8'h00;
    localparam logic [7:0]  OFF_STATUS    = 8'h04;
    localparam logic [7:0]  OFF_RDATA     = 8'h08;
    localparam int          CTRL_SEL_LSB  = 0;
    localparam int          CTRL_WD_LSB   = 8;
    localparam int          CTRL_WR_BIT   = 16;

    typedef enum logic [1:0] {
        HOST_IDLE,
        HOST_ISSUE,
        HOST_WAIT
    } host_state_e;

endpackage : capture_pkg

/* src/capture_if.sv */
// host port joining the capture device and its controller
`timescale 1ns/1ps

interface capture_if;
    import capture_pkg::*;

    logic [SEL_W-1:0] sel;
    logic             rd;
    logic             wr;
    logic [7:0]       wdata;
    logic [7:0]       rdata;
    logic             rvalid;

    modport dev (
        input  sel,
        input  rd,
        input  wr,
        input  wdata,
        output rdata,
        output rvalid
    );

    modport host (
        output sel,
        output rd,
        output wr,
        output wdata,
        input  rdata,
        input  rvalid
    );

endinterface : capture_if

/* src/edge_trigger.sv */
// edge detector on the trigger bit of the pixel stream
`timescale 1ns/1ps

module edge_trigger (
    // clock and reset
    input  wire logic core_clk,
    input  wire logic reset,
    // trigger
    input  wire logic trig_bit,
    input  wire logic rise_sel,
    output wire logic fire
);

    logic prev_reg;

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            prev_reg <= 1'b0;
        end else begin
            prev_reg <= trig_bit;
        end
    end

    // the opposite edge never fires
    assign fire = (trig_bit != prev_reg) && (trig_bit == rise_sel);

endmodule : edge_trigger

/* src/test_capture_device.sv */
// device end: pixel and converter stage capture with host port registers
`timescale 1ns/1ps

module test_capture_device
    import capture_pkg::*;
(
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        reset,
    // host port
    capture_if.dev           hp,
    // pixel input stage
    input  wire logic [7:0]  pix_red,
    input  wire logic [7:0]  pix_green,
    input  wire logic [7:0]  pix_blue,
    // converter stage, CONV_DELAY clocks behind the input stage
    input  wire logic [9:0]  conv_red,
    input  wire logic [9:0]  conv_green,
    input  wire logic [9:0]  conv_blue,
    input  wire logic        conv_sync,
    input  wire logic        conv_blank_n,
    input  wire logic        conv_pll,
    // configuration view
    output logic      [7:0]  cmd2_view,
    output logic      [7:0]  pix_mask_view
);

    // -----------------------------------------------------------------
    // state
    // -----------------------------------------------------------------
    logic [7:0]            cmd2_reg;
    logic [7:0]            mask_reg;
    logic [23:0]           pix_cap_reg;
    logic [29:0]           conv_cap_reg;
    logic [2:0]            stat_cap_reg;
    logic [CONV_DELAY-1:0] fire_pipe_reg;
    logic [2:0]            seq_reg;
    logic [SEL_W-1:0]      last_sel_reg;
    logic [7:0]            rdata_reg;
    logic                  rvalid_reg;

    // -----------------------------------------------------------------
    // trigger
    // -----------------------------------------------------------------
    wire        fire;
    wire        conv_fire;

    edge_trigger u_trig (
        .core_clk (core_clk),
        .reset    (reset),
        .trig_bit (pix_red[RED_TOP]),
        .rise_sel (cmd2_reg[CMD2_EDGE_BIT]),
        .fire     (fire)
    );

    // the trigger travels with its pixel, so the converter capture
    // lands on the same pixel without stopping the clock
    assign conv_fire = fire_pipe_reg[CONV_DELAY-1];

    // -----------------------------------------------------------------
    // converter stage data
    // -----------------------------------------------------------------
    wire        eight_bit;
    wire        six_fmt;
    wire [9:0]  conv_r_m;
    wire [9:0]  conv_g_m;
    wire [9:0]  conv_b_m;
    wire [29:0] conv_word;
    wire [2:0]  stat_word;

    assign eight_bit = cmd2_reg[CMD2_8BIT_BIT];
    assign six_fmt   = cmd2_reg[CMD2_SIX_BIT];

    assign conv_r_m  = eight_bit ? {2'h0, conv_red[7:0]}   : conv_red;
    assign conv_g_m  = eight_bit ? {2'h0, conv_green[7:0]} : conv_green;
    assign conv_b_m  = eight_bit ? {2'h0, conv_blue[7:0]}  : conv_blue;

    // blank is active low at the pin
    assign conv_word = conv_blank_n ? {conv_r_m, conv_g_m, conv_b_m} : 30'h0;
    assign stat_word = {conv_pll, conv_blank_n, conv_sync};

    // -----------------------------------------------------------------
    // capture registers
    // -----------------------------------------------------------------
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            fire_pipe_reg <= '0;
        end else begin
            fire_pipe_reg <= {fire_pipe_reg[CONV_DELAY-2:0], fire};
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            pix_cap_reg <= 24'h0;
        end else if (fire) begin
            pix_cap_reg <= {pix_red, pix_green, pix_blue};
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            conv_cap_reg <= 30'h0;
            stat_cap_reg <= 3'h0;
        end else if (conv_fire) begin
            conv_cap_reg <= conv_word;
            stat_cap_reg <= stat_word;
        end
    end

    // -----------------------------------------------------------------
    // host port read sequencing
    // -----------------------------------------------------------------
    // a byte counter walks through a multi-byte register; it restarts
    // whenever another register is selected or any write is made
    wire        same_sel;
    wire [2:0]  seq_cur;
    wire [2:0]  seq_inc;
    wire [2:0]  seq_limit;
    wire [2:0]  seq_adv;
    wire [1:0]  conv_col;
    wire        conv_half;
    wire [9:0]  conv_pick;
    wire [7:0]  conv_byte;
    wire [7:0]  pix_byte;
    wire [7:0]  rd_byte;
    wire        sel_pix;
    wire        sel_conv;

    assign sel_pix   = hp.sel == IDX_PIX_CAP;
    assign sel_conv  = hp.sel == IDX_CONV_CAP;
    assign same_sel  = hp.sel == last_sel_reg;
    assign seq_cur   = same_sel ? seq_reg : 3'h0;
    assign seq_inc   = seq_cur + 3'h1;

    assign seq_limit = sel_pix  ? SEQ_THREE :
                       sel_conv ? (six_fmt ? SEQ_SIX : SEQ_THREE) :
                       SEQ_ONE;
    assign seq_adv   = (seq_inc >= seq_limit) ? 3'h0 : seq_inc;

    assign pix_byte  = (seq_cur == 3'h0) ? pix_cap_reg[23:16] :
                       (seq_cur == 3'h1) ? pix_cap_reg[15:8]  :
                       pix_cap_reg[7:0];

    // six-access format: low byte then top two bits of each colour
    assign conv_col  = six_fmt ? seq_cur[2:1] : seq_cur[1:0];
    assign conv_half = six_fmt & seq_cur[0];
    assign conv_pick = (conv_col == 2'h0) ? conv_cap_reg[29:20] :
                       (conv_col == 2'h1) ? conv_cap_reg[19:10] :
                       conv_cap_reg[9:0];
    assign conv_byte = conv_half ? {6'h0, conv_pick[9:8]} : conv_pick[7:0];

    // upper status bits read as zero
    assign rd_byte   = (hp.sel == IDX_CMD2)     ? cmd2_reg  :
                       (hp.sel == IDX_PIX_MASK) ? mask_reg  :
                       sel_pix                  ? pix_byte  :
                       sel_conv                 ? conv_byte :
                       (hp.sel == IDX_STAT_CAP) ? {5'h0, stat_cap_reg} :
                       8'h0;

    // -----------------------------------------------------------------
    // host port registers
    // -----------------------------------------------------------------
    // capture registers have no write path at all
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            cmd2_reg <= CMD2_RESET;
            mask_reg <= MASK_RESET;
        end else if (hp.wr) begin
            if (hp.sel == IDX_CMD2) begin
                cmd2_reg <= hp.wdata;
            end
            if (hp.sel == IDX_PIX_MASK) begin
                mask_reg <= hp.wdata;
            end
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            seq_reg      <= 3'h0;
            last_sel_reg <= '0;
        end else if (hp.wr) begin
            seq_reg      <= 3'h0;
            last_sel_reg <= hp.sel;
        end else if (hp.rd) begin
            seq_reg      <= seq_adv;
            last_sel_reg <= hp.sel;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            rdata_reg  <= 8'h0;
            rvalid_reg <= 1'b0;
        end else begin
            rvalid_reg <= hp.rd & ~hp.wr;
            if (hp.rd & ~hp.wr) begin
                rdata_reg <= rd_byte;
            end
        end
    end

    // -----------------------------------------------------------------
    // outputs
    // -----------------------------------------------------------------
    assign hp.rdata      = rdata_reg;
    assign hp.rvalid     = rvalid_reg;
    assign cmd2_view     = cmd2_reg;
    assign pix_mask_view = mask_reg;

endmodule : test_capture_device

/* src/test_capture_host.sv */
// controller end: AHB-Lite registers driving the host port
`timescale 1ns/1ps

module test_capture_host
    import capture_pkg::*;
(
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        reset,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // host port
    capture_if.host          hp
);

    // -----------------------------------------------------------------
    // bus slave, zero wait states
    // -----------------------------------------------------------------
    host_state_e      state_reg;
    logic             wr_pend_reg;
    logic [7:0]       addr_reg;
    logic [31:0]      hrdata_reg;
    logic [7:0]       byte_reg;
    logic [SEL_W-1:0] sel_reg;
    logic [7:0]       wdata_reg;
    logic             do_wr_reg;
    logic             rd_reg;
    logic             wr_reg;

    wire        addr_ph;
    wire        busy;
    wire        start;
    wire [31:0] rd_word;

    assign addr_ph = hsel & hready & htrans[1];
    assign busy    = state_reg != HOST_IDLE;
    // a new order while busy is dropped; software polls busy first
    assign start   = wr_pend_reg & (addr_reg == OFF_CTRL) & ~busy;
    assign rd_word = (haddr[7:0] == OFF_STATUS) ? {31'h0, busy} :
                     (haddr[7:0] == OFF_RDATA)  ? {24'h0, byte_reg} :
                     32'h0;

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            wr_pend_reg <= 1'b0;
            addr_reg    <= 8'h0;
            hrdata_reg  <= 32'h0;
        end else begin
            wr_pend_reg <= addr_ph & hwrite;
            if (addr_ph) begin
                addr_reg <= haddr[7:0];
            end
            if (addr_ph & ~hwrite) begin
                hrdata_reg <= rd_word;
            end
        end
    end

    // -----------------------------------------------------------------
    // host port sequencer
    // -----------------------------------------------------------------
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            state_reg <= HOST_IDLE;
            sel_reg   <= '0;
            wdata_reg <= 8'h0;
            do_wr_reg <= 1'b0;
            rd_reg    <= 1'b0;
            wr_reg    <= 1'b0;
            byte_reg  <= 8'h0;
        end else begin
            rd_reg <= 1'b0;
            wr_reg <= 1'b0;
            unique case (state_reg)
                HOST_IDLE: begin
                    if (start) begin
                        sel_reg   <= hwdata[CTRL_SEL_LSB +: SEL_W];
                        wdata_reg <= hwdata[CTRL_WD_LSB +: 8];
                        do_wr_reg <= hwdata[CTRL_WR_BIT];
                        state_reg <= HOST_ISSUE;
                    end
                end
                HOST_ISSUE: begin
                    rd_reg    <= ~do_wr_reg;
                    wr_reg    <= do_wr_reg;
                    state_reg <= do_wr_reg ? HOST_IDLE : HOST_WAIT;
                end
                HOST_WAIT: begin
                    if (hp.rvalid) begin
                        byte_reg  <= hp.rdata;
                        state_reg <= HOST_IDLE;
                    end
                end
            endcase
        end
    end

    // -----------------------------------------------------------------
    // outputs
    // -----------------------------------------------------------------
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            hreadyout <= 1'b0;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    assign hrdata   = hrdata_reg;
    assign hp.sel   = sel_reg;
    assign hp.wdata = wdata_reg;
    assign hp.rd    = rd_reg;
    assign hp.wr    = wr_reg;

endmodule : test_capture_host

/* dv/capture_chk.sv */
// host port protocol checker for the capture link
`timescale 1ns/1ps

module capture_chk
    import capture_pkg::*;
(
    // clock and reset
    input wire logic             core_clk,
    input wire logic             reset,
    // host port
    input wire logic [SEL_W-1:0] sel,
    input wire logic             rd,
    input wire logic             wr,
    input wire logic [7:0]       wdata,
    input wire logic [7:0]       rdata,
    input wire logic             rvalid
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);

    // ----------------------------------------------------------------
    // access steps
    // ----------------------------------------------------------------
    sequence s_read;
        rd && !wr;
    endsequence
    sequence s_quiet2;
        (!rd && !wr)[*2];
    endsequence

    a_read_answer: assert property (s_read |=> rvalid)
        else $error("read got no answer one cycle later");
    a_answer_cause: assert property (rvalid |-> $past(rd) && !$past(wr))
        else $error("answer without a read before it");
    a_write_silent: assert property (wr |=> !rvalid)
        else $error("write was answered");
    a_answer_single: assert property (rvalid |=> !rvalid)
        else $error("answer longer than one cycle");
    a_rdata_hold: assert property (!rvalid |-> $stable(rdata))
        else $error("read byte changed without an answer");
    a_sel_held: assert property (s_read |=> $stable(sel))
        else $error("index moved before the answer");
    a_access_single: assert property (rd |-> !wr)
        else $error("read and write together");
    a_access_spacing: assert property ((rd || wr) |=> s_quiet2)
        else $error("accesses too close");
endmodule : capture_chk

/* dv/tb.sv */
// self-checking bench: AHB-Lite controller driving the capture device
`timescale 1ns/1ps

module tb;
    import capture_pkg::*;

    logic        core_clk  = 1'b0;
    logic        reset     = 1'b1;
    logic        hsel      = 1'b0;
    logic [31:0] haddr     = 32'h0;
    logic [1:0]  htrans    = 2'h0;
    logic        hwrite    = 1'b0;
    logic [31:0] hwdata    = 32'h0;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic [7:0]  p_r       = 8'h0;
    logic [7:0]  p_g       = 8'h0;
    logic [7:0]  p_b       = 8'h0;
    logic [2:0]  p_st      = 3'h2;
    logic [26:0] dl [0:3]  = '{default: 27'h0};
    logic [7:0]  cmd2_view;
    logic [7:0]  pix_mask_view;
    int          n_fail    = 0;
    int          cmp_count = 0;
    int          cycles    = 0;
    // expected capture contents, {pll, blank_n, sync} in the status
    logic        last_top  = 1'b0;
    logic [7:0]  cmd       = CMD2_RESET;
    logic [23:0] e_pix     = 24'h0;
    logic [29:0] e_conv    = 30'h0;
    logic [2:0]  e_st      = 3'h0;

    always #2 core_clk = ~core_clk;

    capture_if hp ();

    test_capture_device test_capture_device_inst (
        .core_clk     (core_clk),
        .reset        (reset),
        .hp           (hp),
        .pix_red      (p_r),
        .pix_green    (p_g),
        .pix_blue     (p_b),
        .conv_red     ({dl[3][17:16], dl[3][23:16]}),
        .conv_green   ({dl[3][9:8], dl[3][15:8]}),
        .conv_blue    ({dl[3][1:0], dl[3][7:0]}),
        .conv_sync    (dl[3][24]),
        .conv_blank_n (dl[3][25]),
        .conv_pll     (dl[3][26]),
        .cmd2_view    (cmd2_view),
        .pix_mask_view(pix_mask_view)
    );

    test_capture_host test_capture_host_inst (
        .core_clk (core_clk),
        .reset    (reset),
        .hsel     (hsel),
        .haddr    (haddr),
        .htrans   (htrans),
        .hwrite   (hwrite),
        .hsize    (3'h2),
        .hwdata   (hwdata),
        .hready   (hreadyout),
        .hrdata   (hrdata),
        .hreadyout(hreadyout),
        .hresp    (hresp),
        .hp       (hp)
    );

    capture_chk capture_chk_inst (
        .core_clk(core_clk),
        .reset   (reset),
        .sel     (hp.sel),
        .rd      (hp.rd),
        .wr      (hp.wr),
        .wdata   (hp.wdata),
        .rdata   (hp.rdata),
        .rvalid  (hp.rvalid)
    );

    // converter stage sees each pixel four clocks later
    always @(posedge core_clk) begin
        dl[0] <= {p_st, p_r, p_g, p_b};
        dl[1] <= dl[0];
        dl[2] <= dl[1];
        dl[3] <= dl[2];
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            n_fail++;
            summarize();
        end
    end

    // ----------------------------------------------------------------
    // access tasks
    // ----------------------------------------------------------------
    task automatic summarize();
        if (n_fail == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : summarize

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            n_fail++;
        end
    endtask : chk

    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge core_clk);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
        // the slave never signals an error
        chk({31'h0, hresp}, 32'h0);
    endtask : ahb

    task automatic dev(input logic w, input logic [3:0] s, input logic [7:0] wb,
                       output logic [7:0] rb);
        logic [31:0] d;
        ahb(1'b1, OFF_CTRL, {15'h0, w, wb, 4'h0, s}, d);
        do ahb(1'b0, OFF_STATUS, 32'h0, d); while (d[0] !== 1'b0);
        ahb(1'b0, OFF_RDATA, 32'h0, d);
        rb = d[7:0];
    endtask : dev

    task automatic rchk(input logic [3:0] s, input logic [7:0] exp);
        logic [7:0] b;
        dev(1'b0, s, 8'h0, b);
        chk({24'h0, b}, {24'h0, exp});
    endtask : rchk

    task automatic cfg(input logic [7:0] c);
        logic [7:0] b;
        dev(1'b1, IDX_CMD2, c, b);
        cmd = c;
        chk({24'h0, cmd2_view}, {24'h0, c});
    endtask : cfg

    // one pixel; the model mirrors what a qualifying edge captures
    task automatic px(input logic [7:0] r, g, b, input logic [2:0] st);
        if (cmd[CMD2_EDGE_BIT] ? (!last_top && r[7]) : (last_top && !r[7])) begin
            e_pix  = {r, g, b};
            e_conv = st[1] ? {r[1:0], r, g[1:0], g, b[1:0], b} : 30'h0;
            if (cmd[CMD2_8BIT_BIT])
                e_conv &= {3{10'h0ff}};
            e_st = st;
        end
        last_top = r[7];
        @(posedge core_clk);
        p_r  <= r;
        p_g  <= g;
        p_b  <= b;
        p_st <= st;
    endtask : px

    // each call reads out only the latest capture; the last block sends two trigger pixels before it
    task automatic check_all();
        repeat (6) @(posedge core_clk);
        rchk(IDX_PIX_CAP, e_pix[23:16]);
        rchk(IDX_PIX_CAP, e_pix[15:8]);
        rchk(IDX_PIX_CAP, e_pix[7:0]);
        rchk(IDX_PIX_CAP, e_pix[23:16]);
        for (int i = 0; i < 3; i++) begin
            rchk(IDX_CONV_CAP, e_conv[27-10*i -: 8]);
            if (cmd[CMD2_SIX_BIT])
                rchk(IDX_CONV_CAP, {6'h0, e_conv[29-10*i -: 2]});
        end
        // the check compares all eight bits; this end drives the upper five as zero
        rchk(IDX_STAT_CAP, {5'h0, e_st});
    endtask : check_all

    // ----------------------------------------------------------------
    // test sequence
    // ----------------------------------------------------------------
    initial begin
        logic [7:0]  b;
        logic [31:0] d;
        repeat (20) @(posedge core_clk);
        reset <= 1'b0;
        chk({24'h0, cmd2_view}, {24'h0, CMD2_RESET});
        chk({24'h0, pix_mask_view}, {24'h0, MASK_RESET});
        rchk(IDX_CMD2, CMD2_RESET);
        rchk(IDX_PIX_MASK, MASK_RESET);
        dev(1'b1, IDX_PIX_MASK, 8'h3c, b);
        chk({24'h0, pix_mask_view}, 32'h3c);
        rchk(IDX_PIX_MASK, 8'h3c);
        ahb(1'b0, 8'h0c, 32'h0, d);
        chk(d, 32'h0);
        check_all();
        px(8'h00, 8'h11, 8'h22, 3'h2);
        px(8'h9a, 8'h5b, 8'h3c, 3'h3);
        px(8'h05, 8'h66, 8'h77, 3'h4);
        check_all();
        cfg(8'h00);
        dev(1'b1, IDX_PIX_CAP, 8'h55, b);
        px(8'hc0, 8'h12, 8'h34, 3'h7);
        check_all();
        cfg(8'h04);
        px(8'h6e, 8'h77, 8'h88, 3'h3);
        check_all();
        cfg(8'h07);
        px(8'hd5, 8'he6, 8'hf7, 3'h6);
        px(8'h00, 8'h00, 8'h00, 3'h2);
        check_all();
        cfg(8'h01);
        px(8'hb3, 8'hc4, 8'hd5, 3'h5);
        check_all();
        px(8'h01, 8'h02, 8'h03, 3'h2);
        px(8'h81, 8'h0a, 8'h0b, 3'h2);
        px(8'h02, 8'h04, 8'h06, 3'h2);
        px(8'h83, 8'h1c, 8'h2d, 3'h3);
        px(8'h04, 8'h08, 8'h0c, 3'h2);
        check_all();
        summarize();
    end
endmodule : tb
